// >>> hw/laser_driver_control_regs.sv
/*
  Control and status register bank of a serially configured laser
  driver, reached by a host over the two-wire management bus.
  Assumes SCK and SDA arrive asynchronously on pins, the fault input is
  asynchronous, and the converter result is on this clock.
*/
// Notes on behaviour
// - Control bit 7 enables or disables chip
// - Enable low then high clears latched fault
// - Range bits 6:5 select 770/1540/3080 full scale
// - Bit 4 selects open-loop or closed-loop control
// - Bit 3 switches fault detection on or off
// - Bit 2 swaps differential output pin polarity
// - Bit 1 enables equalizer, else bypassed
// - Bit 0 sets photodiode connection sense
// - Converter result read-only at 0x0E and 0x0F
// - One address, register, data byte per transfer
`timescale 1ns/1ps
`include "laser_driver_consts.svh"

module laser_driver_control_regs #(
  parameter logic [6:0] DEVICE_ADDR = `DEV_ADDR
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Analog side inputs
  input wire logic fault_in,
  input wire logic [9:0] adc_result,
  // Control outputs
  output laser_driver_pkg::main_ctrl_s main_ctrl,
  output laser_driver_pkg::adjust_s adjust,
  output logic [2:0] range_sel,
  output logic fault_latched,
  output logic drive_enable
);

  // ==========================================================
  // Address map helpers
  function automatic logic [7:0] bit_mask(input logic [7:0] a);
    unique case (a)
      `REG_MAIN, `REG_EQ, `REG_XPT, `REG_LIM, `REG_BFT, `REG_PFT: bit_mask = `MASK_FULL;
      `REG_OUT: bit_mask = `MASK_OUT;
      `REG_MON: bit_mask = `MASK_MON;
      `REG_CONV: bit_mask = `MASK_CONV;
      default: bit_mask = `MASK_NONE;
    endcase
  endfunction

  function automatic logic [7:0] fixed_ones(input logic [7:0] a);
    fixed_ones = (a == `REG_CONV) ? `ONES_CONV : `RESET_BYTE;
  endfunction

  function automatic logic [2:0] range_decode(input logic [1:0] r);
    unique case (r)
      `PDR_770: range_decode = `RANGE_770;
      `PDR_1540: range_decode = `RANGE_1540;
      default: range_decode = `RANGE_3080;
    endcase
  endfunction

  laser_driver_pkg::ctrl_state_s q, d;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [`REG_COUNT-1:0][7:0] contents;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic [7:0] tx_byte;

  // ==========================================================
  // Register memory
  reg_store #(
    .WIDTH(8),
    .DEPTH(`REG_COUNT),
    .AW(4)
  ) reg_store_i (
    .clock(clock),
    .reset_n(reset_n),
    .wr_en(wr_en),
    .wr_addr(q.ptr[3:0]),
    .wr_data(wr_data),
    .rd_addr(q.ptr[3:0]),
    .rd_data(rd_data),
    .contents(contents)
  );

  // ==========================================================
  // Bus events from synchronised pins
  assign scl_rise = q.scl_s2 & ~q.scl_p;
  assign scl_fall = ~q.scl_s2 & q.scl_p;
  assign start_cond = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
  assign stop_cond = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;

  // Read byte for the current pointer
  always_comb
  begin
    if (q.ptr == `REG_ADC_HI)
    begin
      tx_byte = adc_result[`ADC_HI_MSB:`ADC_HI_LSB];
    end
    else if (q.ptr == `REG_ADC_LO)
    begin
      tx_byte = {6'h00, q.adc_low};
    end
    else
    begin
      tx_byte = (rd_data & bit_mask(q.ptr)) | fixed_ones(q.ptr);
    end
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    d = q;
    wr_en = 1'b0;
    wr_data = `RESET_BYTE;
    // Pin synchronisers and edge history
    d.scl_s1 = scl_in;
    d.scl_s2 = q.scl_s1;
    d.scl_p = q.scl_s2;
    d.sda_s1 = sda_in;
    d.sda_s2 = q.sda_s1;
    d.sda_p = q.sda_s2;
    d.flt_s1 = fault_in;
    d.flt_s2 = q.flt_s1;
    d.sda_o = 1'b0;
    if (stop_cond)
    begin
      d.st = laser_driver_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
    end
    else if (start_cond)
    begin
      d.st = laser_driver_pkg::ST_ADDR;
      d.cnt = 3'h0;
      d.sda_oe = 1'b0;
    end
    else
    begin
      unique case (q.st)
        laser_driver_pkg::ST_IDLE, laser_driver_pkg::ST_IGNORE:
        begin
          d.sda_oe = 1'b0;
        end
        laser_driver_pkg::ST_ADDR:
        begin
          if (scl_rise)
          begin
            d.shift = {q.shift[6:0], q.sda_s2};
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == `LAST_BIT)
            begin
              d.rw = q.sda_s2;
              d.st = (q.shift[6:0] == DEVICE_ADDR) ? laser_driver_pkg::ST_ACK_ADDR
                : laser_driver_pkg::ST_IGNORE;
            end
          end
        end
        laser_driver_pkg::ST_ACK_ADDR:
        begin
          if (scl_fall)
          begin
            d.sda_oe = ~q.sda_oe;
            d.cnt = 3'h0;
            if (q.sda_oe && q.rw)
            begin
              d.st = laser_driver_pkg::ST_TX;
              d.shift = tx_byte;
              d.sda_oe = ~tx_byte[7];
              if (q.ptr == `REG_ADC_HI)
              begin
                d.adc_low = adc_result[`ADC_LO_MSB:0];
              end
            end
            else if (q.sda_oe)
            begin
              d.st = laser_driver_pkg::ST_REG;
            end
          end
        end
        laser_driver_pkg::ST_REG, laser_driver_pkg::ST_WDATA:
        begin
          if (scl_rise)
          begin
            d.shift = {q.shift[6:0], q.sda_s2};
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == `LAST_BIT && q.st == laser_driver_pkg::ST_REG)
            begin
              d.ptr = {q.shift[6:0], q.sda_s2};
              d.st = laser_driver_pkg::ST_ACK_REG;
            end
            else if (q.cnt == `LAST_BIT)
            begin
              wr_en = (bit_mask(q.ptr) != `MASK_NONE);
              wr_data = ({q.shift[6:0], q.sda_s2} & bit_mask(q.ptr)) | fixed_ones(q.ptr);
              d.st = laser_driver_pkg::ST_ACK_DATA;
            end
          end
        end
        laser_driver_pkg::ST_ACK_REG, laser_driver_pkg::ST_ACK_DATA:
        begin
          if (scl_fall)
          begin
            d.sda_oe = ~q.sda_oe;
            d.cnt = 3'h0;
            if (q.sda_oe)
            begin
              d.st = (q.st == laser_driver_pkg::ST_ACK_REG) ? laser_driver_pkg::ST_WDATA
                : laser_driver_pkg::ST_IGNORE;
            end
          end
        end
        laser_driver_pkg::ST_TX:
        begin
          if (scl_fall)
          begin
            d.cnt = q.cnt + 3'h1;
            d.shift = {q.shift[6:0], 1'b0};
            d.sda_oe = ~q.shift[6];
            if (q.cnt == `LAST_BIT)
            begin
              d.sda_oe = 1'b0;
              d.st = laser_driver_pkg::ST_IGNORE;
            end
          end
        end
        default:
        begin
          d.st = laser_driver_pkg::ST_IDLE;
        end
      endcase
    end
    // Fault latch, chip enable and range decode
    d.en_p = main_ctrl.chip_enable;
    d.fault = (q.flt_s2 & main_ctrl.fault_detect_enable & main_ctrl.chip_enable)
      | (q.fault & ~(main_ctrl.chip_enable & ~q.en_p));
    d.drive_en = main_ctrl.chip_enable & ~q.fault;
    d.range_sel = range_decode(main_ctrl.photodiode_range);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.st <= laser_driver_pkg::ST_IDLE;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_p <= 1'b1;
      q.range_sel <= `RANGE_770;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign main_ctrl = laser_driver_pkg::main_ctrl_s'(contents[`REG_MAIN]);
  assign adjust = laser_driver_pkg::adjust_s'(contents[`REG_CONV:`REG_EQ]);
  assign range_sel = q.range_sel;
  assign fault_latched = q.fault;
  assign drive_enable = q.drive_en;
  assign sda_out = q.sda_o;
  assign sda_oe = q.sda_oe;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  AST_DISABLE_OFF: assert property (!main_ctrl.chip_enable |=> !drive_enable)
    else $error("drive enable high while chip disabled");
  AST_FAULT_CLEAR: assert property ($rose(main_ctrl.chip_enable) && !q.flt_s2 |=> !fault_latched)
    else $error("fault not cleared by enable toggle");
  AST_FAULT_HOLD: assert property (fault_latched && $stable(main_ctrl.chip_enable) |=> fault_latched)
    else $error("fault cleared without enable toggle");
  AST_RANGE_HIGH: assert property (main_ctrl.photodiode_range[1] |=> range_sel == `RANGE_3080)
    else $error("range select wrong for high range");
  AST_DETECT_OFF: assert property (!main_ctrl.fault_detect_enable && !fault_latched |=> !fault_latched)
    else $error("fault latched with detection off");
  AST_CTRL_WRITE: assert property (wr_en && q.ptr == `REG_MAIN |=> contents[`REG_MAIN] == $past(wr_data))
    else $error("main control write not stored");
  AST_RO_WRITE: assert property (wr_en |-> q.ptr < `REG_ADC_HI)
    else $error("write reached read-only register");
  AST_MON_UNUSED: assert property (contents[`REG_MON] == (contents[`REG_MON] & `MASK_MON))
    else $error("unused monitor bits hold ones");
  AST_ACK_DRIVE: assert property (q.st == laser_driver_pkg::ST_ACK_ADDR && !sda_oe && scl_fall |=> sda_oe)
    else $error("address acknowledge not driven");
  AST_STOP_IDLE: assert property (stop_cond |=> q.st == laser_driver_pkg::ST_IDLE && !sda_oe)
    else $error("stop did not release bus");

  COV_WRITE_MAIN: cover property (wr_en && q.ptr == `REG_MAIN);
  COV_READ_ADC: cover property (q.st == laser_driver_pkg::ST_TX && q.ptr == `REG_ADC_HI);
  COV_FAULT_CLEAR: cover property (fault_latched ##[1:1000] !fault_latched);

endmodule

// >>> hw/reg_store.sv
/*
  Small register memory: one write port, one registered read port and
  every stored word exposed as flip-flop outputs.
  Assumes write and read requests come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "laser_driver_consts.svh"

module reg_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `REG_COUNT,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data,
  // All stored words
  output logic [DEPTH-1:0][WIDTH-1:0] contents
);

  // ==========================================================
  // Parameter check
  if (DEPTH != (1 << AW) || WIDTH < 1)
  begin : g_bad
    $error("reg_store: DEPTH must equal 2**AW and WIDTH be positive");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd;
  } store_s;

  store_s q, d;

  // ==========================================================
  // Next state: write, then registered read
  always_comb
  begin
    d = q;
    if (wr_en)
    begin
      d.mem[wr_addr] = wr_data;
    end
    d.rd = q.mem[rd_addr];
  end

  // State register
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign rd_data = q.rd;
  assign contents = q.mem;

endmodule

// >>> inc/laser_driver_consts.svh
/*
  Constants of the laser driver control register bank: bus address,
  register offsets, write masks, fixed bits, reset values and range codes.
  Assumes it is included by the design modules and by the bench.
*/
`ifndef LASER_DRIVER_CONSTS_SVH
`define LASER_DRIVER_CONSTS_SVH

// ==========================================================
// Two-wire bus target address
`define DEV_ADDR 7'h08

// ==========================================================
// Register offsets
`define REG_MAIN 8'h00
`define REG_EQ 8'h06
`define REG_XPT 8'h07
`define REG_OUT 8'h08
`define REG_LIM 8'h09
`define REG_MON 8'h0A
`define REG_BFT 8'h0B
`define REG_PFT 8'h0C
`define REG_CONV 8'h0D
`define REG_ADC_HI 8'h0E
`define REG_ADC_LO 8'h0F
`define REG_COUNT 16

// ==========================================================
// Writable bits and bits fixed at one
`define MASK_FULL 8'hFF
`define MASK_OUT 8'h9F
`define MASK_MON 8'h07
`define MASK_CONV 8'hC3
`define MASK_NONE 8'h00
`define ONES_CONV 8'h14
`define RESET_BYTE 8'h00

// ==========================================================
// Photodiode range codes and one-hot range selects
`define PDR_770 2'h0
`define PDR_1540 2'h1
`define RANGE_770 3'h1
`define RANGE_1540 3'h2
`define RANGE_3080 3'h4

// ==========================================================
// Converter result split and bit counting
`define ADC_HI_MSB 9
`define ADC_HI_LSB 2
`define ADC_LO_MSB 1
`define LAST_BIT 3'h7

`endif

// >>> inc/laser_driver_pkg.sv
/*
  Types of the laser driver control register bank: bus states, the
  control field carriers and the packed state of the top module.
  Assumes the constants header is on the include path.
*/
package laser_driver_pkg;

  // Two-wire bus slave states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG, ST_WDATA, ST_ACK_DATA, ST_TX, ST_IGNORE
  } bus_state_e;

  // Main control register fields, bit 7 first
  typedef struct packed {
    logic chip_enable;
    logic [1:0] photodiode_range;
    logic open_loop_select;
    logic fault_detect_enable;
    logic output_swap;
    logic equalizer_enable;
    logic photodiode_sense;
  } main_ctrl_s;

  // Adjust registers, highest offset first
  typedef struct packed {
    logic [7:0] converter_settings;
    logic [7:0] power_fault_threshold;
    logic [7:0] bias_fault_threshold;
    logic [7:0] monitor_settings;
    logic [7:0] limiter_bias_adjust;
    logic [7:0] output_adjust;
    logic [7:0] crosspoint_adjust;
    logic [7:0] equalizer_adjust;
  } adjust_s;

  // Whole state of the top module
  typedef struct packed {
    bus_state_e st;
    logic [2:0] cnt;
    logic [7:0] shift;
    logic rw;
    logic [7:0] ptr;
    logic sda_oe;
    logic sda_o;
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    logic flt_s1;
    logic flt_s2;
    logic en_p;
    logic fault;
    logic drive_en;
    logic [2:0] range_sel;
    logic [1:0] adc_low;
  } ctrl_state_s;

endpackage

// >>> verification/bus_host_model.sv
/*
  Two-wire bus host model: start, repeated start, stop, byte writes and reads.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/1ps

module bus_host_model #(
  parameter int QTR = 7
) (
  // Clock
  input wire logic clock,
  // Bus lines
  output logic scl,
  output logic sda_pull,
  input wire logic sda_wire
);
  // ==========================================================
  // Bus idle at time zero
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Wait n clocks, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // One bit, data set in the low phase; wire sampled mid-high
  task automatic bit_io(input logic b, output logic got);
    sda_pull = ~b;
    tick(QTR);
    scl = 1'b1;
    tick(QTR);
    got = sda_wire;
    tick(QTR);
    scl = 1'b0;
    tick(QTR);
  endtask

  // Eight bits MSB first, then the acknowledge slot released
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(1'b1, ack);
  endtask

  // Start or repeated start: data falls while clock high
  task automatic start_cond();
    sda_pull = 1'b0;
    tick(QTR);
    scl = 1'b1;
    tick(QTR);
    sda_pull = 1'b1;
    tick(QTR);
    scl = 1'b0;
    tick(QTR);
  endtask

  // Stop: data rises while clock high
  task automatic stop_cond();
    sda_pull = 1'b1;
    tick(QTR);
    scl = 1'b1;
    tick(QTR);
    sda_pull = 1'b0;
    tick(QTR);
  endtask

  // Single-byte register write
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] wd,
                           output logic [2:0] acks);
    logic [7:0] rx;
    start_cond();
    byte_io({dev, 1'b0}, rx, acks[2]);
    byte_io(ra, rx, acks[1]);
    byte_io(wd, rx, acks[0]);
    stop_cond();
  endtask

  // Single-byte register read through a repeated start, ended by a nack
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ra, output logic [7:0] rd,
                          output logic [2:0] acks);
    logic [7:0] rx;
    logic nk;
    start_cond();
    byte_io({dev, 1'b0}, rx, acks[2]);
    byte_io(ra, rx, acks[1]);
    start_cond();
    byte_io({dev, 1'b1}, rx, acks[0]);
    byte_io(8'hFF, rd, nk);
    stop_cond();
  endtask
endmodule

// >>> verification/tb_laser_driver_control_regs.sv
/*
  Self-checking bench of the laser driver register bank.
  Assumes the host model file and the constants header are compiled first.
*/
`timescale 1ns/1ps
`include "laser_driver_consts.svh"

module tb_laser_driver_control_regs;
  // ==========================================================
  // Signals
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic scl;
  logic sda_pull;
  logic sda_out;
  logic sda_oe;
  logic sda_wire;
  logic fault_in = 1'b0;
  logic [9:0] adc_result = 10'h2A5;
  laser_driver_pkg::main_ctrl_s main_ctrl;
  laser_driver_pkg::adjust_s adjust;
  logic [2:0] range_sel;
  logic fault_latched;
  logic drive_enable;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [2:0] acks;
  logic [7:0] rd;
  logic [7:0] pat[2] = '{8'hFF, 8'h00};
  logic [7:0] ctrl_v[4] = '{8'h8A, 8'hB5, 8'hC0, 8'h63};
  logic [2:0] rng_v[4] = '{3'h1, 3'h2, 3'h4, 3'h4};

  // 10 MHz clock
  always #50 clock = ~clock;

  // Open-drain data wire with pull-up
  assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));

  // ==========================================================
  // Instances
  laser_driver_control_regs laser_driver_control_regs_i (
    .clock(clock), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .fault_in(fault_in), .adc_result(adc_result),
    .main_ctrl(main_ctrl), .adjust(adjust), .range_sel(range_sel),
    .fault_latched(fault_latched), .drive_enable(drive_enable)
  );

  bus_host_model bus_host_model_i (
    .clock(clock), .scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire)
  );

  // ==========================================================
  // Compare, expected readback and verdict
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] exp_rd(input int a, input logic [7:0] p);
    case (a)
      0, 6, 7, 9, 11, 12: return p;
      8: return p & `MASK_OUT;
      10: return p & `MASK_MON;
      13: return (p & `MASK_CONV) | `ONES_CONV;
      14: return adc_result[9:2];
      15: return {6'h00, adc_result[1:0]};
      default: return 8'h00;
    endcase
  endfunction

  task automatic report_and_stop();
    $display("Errors %0d, comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog against a hung bus
  initial
  begin
    repeat (90000) @(posedge clock);
    error_cnt++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clock);
    #1;
    reset_n = 1'b1;
    bus_host_model_i.tick(5);
    check(main_ctrl, 16'h0000);
    check(range_sel, 3'h1);
    check(adjust[15:0], 16'h0000);
    // Whole map written and read back, ones then zeros
    for (int k = 0; k < 2; k++)
    begin
      for (int a = 0; a < 16; a++)
      begin
        bus_host_model_i.write_reg(`DEV_ADDR, 8'(a), pat[k], acks);
        check(acks, 3'b000);
      end
      check(adjust.equalizer_adjust, pat[k]);
      for (int a = 0; a < 16; a++)
      begin
        bus_host_model_i.read_reg(`DEV_ADDR, 8'(a), rd, acks);
        check(acks, 3'b000);
        check(rd, exp_rd(a, pat[k]));
      end
    end
    // Control fields and range decode
    for (int i = 0; i < 4; i++)
    begin
      bus_host_model_i.write_reg(`DEV_ADDR, `REG_MAIN, ctrl_v[i], acks);
      check(main_ctrl, ctrl_v[i]);
      check(range_sel, rng_v[i]);
      check(drive_enable, ctrl_v[i][7]);
    end
    // Fault ignored with detection off, latched with it on
    bus_host_model_i.write_reg(`DEV_ADDR, `REG_MAIN, 8'h80, acks);
    fault_in = 1'b1;
    bus_host_model_i.tick(8);
    check(fault_latched, 1'b0);
    bus_host_model_i.write_reg(`DEV_ADDR, `REG_MAIN, 8'h88, acks);
    check(fault_latched, 1'b1);
    check(drive_enable, 1'b0);
    fault_in = 1'b0;
    // Enable toggled low then high clears the fault
    bus_host_model_i.write_reg(`DEV_ADDR, `REG_MAIN, 8'h08, acks);
    check(fault_latched, 1'b1);
    bus_host_model_i.write_reg(`DEV_ADDR, `REG_MAIN, 8'h88, acks);
    check(fault_latched, 1'b0);
    check(drive_enable, 1'b1);
    // Foreign target address is neither acked nor stored
    bus_host_model_i.write_reg(`DEV_ADDR + 7'h01, `REG_EQ, 8'h3C, acks);
    check(acks, 3'b111);
    bus_host_model_i.read_reg(`DEV_ADDR, `REG_EQ, rd, acks);
    check(rd, 8'h00);
    // Addresses above the map neither store nor alias
    bus_host_model_i.write_reg(`DEV_ADDR, 8'h16, 8'h5A, acks);
    check(acks, 3'b000);
    bus_host_model_i.read_reg(`DEV_ADDR, 8'h16, rd, acks);
    check(rd, 8'h00);
    bus_host_model_i.read_reg(`DEV_ADDR, `REG_EQ, rd, acks);
    check(rd, 8'h00);
    // Low converter bits are the pair captured by the high-byte read
    bus_host_model_i.read_reg(`DEV_ADDR, `REG_ADC_HI, rd, acks);
    check(rd, exp_rd(14, 8'h00));
    adc_result = 10'h15A;
    bus_host_model_i.read_reg(`DEV_ADDR, `REG_ADC_LO, rd, acks);
    check(rd, 8'h01);
    bus_host_model_i.read_reg(`DEV_ADDR, `REG_ADC_HI, rd, acks);
    check(rd, exp_rd(14, 8'h00));
    bus_host_model_i.read_reg(`DEV_ADDR, `REG_ADC_LO, rd, acks);
    check(rd, exp_rd(15, 8'h00));
    report_and_stop();
  end
endmodule
